// [hdl/uef_pkg.sv]
package uef_pkg;

  // ****************************************************************
  // Geometry
  // ****************************************************************
  localparam int unsigned NUM_EP      = 4;
  localparam int unsigned EP_W        = 2;
  localparam int unsigned ADDR_W      = 8;
  localparam int unsigned DATA_W      = 16;
  localparam int unsigned FIFO_BYTE_W = 16;

  // ****************************************************************
  // Register offsets: base + endpoint * stride
  // ****************************************************************
  localparam logic [7:0] EP_STRIDE          = 8'h08;
  localparam logic [2:0] OFS_TX_FIFO_BASE   = 3'h0;
  localparam logic [2:0] OFS_RX_FIFO_BASE   = 3'h1;
  localparam logic [2:0] OFS_TX_FUNC        = 3'h2;
  localparam logic [2:0] OFS_TX_HUB_ID      = 3'h3;
  localparam logic [2:0] OFS_TX_HUB_PORT    = 3'h4;
  localparam logic [2:0] OFS_RX_FUNC        = 3'h5;
  localparam logic [2:0] OFS_RX_HUB_ID      = 3'h6;
  localparam logic [2:0] OFS_RX_HUB_PORT    = 3'h7;

  // ****************************************************************
  // Field layout
  // ****************************************************************
  localparam int unsigned FIFO_BASE_W   = 13;
  localparam int unsigned FIFO_UNIT_SH  = 3;
  localparam int unsigned ID7_W         = 7;
  localparam int unsigned MULT_TT_BIT   = 7;

  // ****************************************************************
  // Reset values
  // ****************************************************************
  localparam logic [12:0] RST_FIFO_BASE = 13'h0000;
  localparam logic [6:0]  RST_ID7       = 7'h00;
  localparam logic        RST_MULT_TT   = 1'b0;

endpackage : uef_pkg

// [hdl/uef_ep_if.sv]
`timescale 1ns/100ps
`default_nettype none

// Per-endpoint fields passed from the register file to the token builder
interface uef_ep_if;
  logic [12:0] tx_fifo_base;
  logic [12:0] rx_fifo_base;
  logic [6:0]  tx_func;
  logic [6:0]  tx_hub;
  logic        tx_mult_tt;
  logic [6:0]  tx_port;
  logic [6:0]  rx_func;
  logic [6:0]  rx_hub;
  logic        rx_mult_tt;
  logic [6:0]  rx_port;

  modport regs (output tx_fifo_base, rx_fifo_base, tx_func, tx_hub, tx_mult_tt, tx_port,
                output rx_func, rx_hub, rx_mult_tt, rx_port);
  modport user (input tx_fifo_base, rx_fifo_base, tx_func, tx_hub, tx_mult_tt, tx_port,
                input rx_func, rx_hub, rx_mult_tt, rx_port);
endinterface : uef_ep_if

`default_nettype wire

// [hdl/uef_ep_regs.sv]
`timescale 1ns/100ps
`default_nettype none

// Storage for one endpoint's eight registers
module uef_ep_regs (
  // Clock and reset
  input  wire logic        i_clk,
  input  wire logic        i_rstn,
  // Write access, already decoded to this endpoint
  input  wire logic        i_wr,
  input  wire logic [2:0]  i_sel,
  input  wire logic [15:0] i_wdata,
  // Read access
  input  wire logic [2:0]  i_rsel,
  output logic      [15:0] o_rdata,
  // Fields
  uef_ep_if.regs           ep
);

  typedef struct packed {
    logic [12:0] tx_base;
    logic [12:0] rx_base;
    logic [6:0]  tx_func;
    logic [6:0]  tx_hub;
    logic        tx_mtt;
    logic [6:0]  tx_port;
    logic [6:0]  rx_func;
    logic [6:0]  rx_hub;
    logic        rx_mtt;
    logic [6:0]  rx_port;
  } uef_epst_t;

  uef_epst_t st_ff;
  uef_epst_t nxt_st;

  // ****************************************************************
  // Next state from writes
  // ****************************************************************
  always_comb begin
    nxt_st = st_ff;
    if (i_wr) begin
      case (i_sel)
        uef_pkg::OFS_TX_FIFO_BASE: nxt_st.tx_base = i_wdata[12:0];  // [RULE1]
        uef_pkg::OFS_RX_FIFO_BASE: nxt_st.rx_base = i_wdata[12:0];  // [RULE2]
        uef_pkg::OFS_TX_FUNC:      nxt_st.tx_func = i_wdata[6:0];
        uef_pkg::OFS_TX_HUB_ID: begin
          nxt_st.tx_mtt = i_wdata[uef_pkg::MULT_TT_BIT];            // [RULE3]
          nxt_st.tx_hub = i_wdata[6:0];                             // [RULE3]
        end
        uef_pkg::OFS_TX_HUB_PORT:  nxt_st.tx_port = i_wdata[6:0];   // [RULE5]
        uef_pkg::OFS_RX_FUNC:      nxt_st.rx_func = i_wdata[6:0];
        uef_pkg::OFS_RX_HUB_ID: begin
          nxt_st.rx_mtt = i_wdata[uef_pkg::MULT_TT_BIT];            // [RULE4]
          nxt_st.rx_hub = i_wdata[6:0];                             // [RULE4]
        end
        uef_pkg::OFS_RX_HUB_PORT:  nxt_st.rx_port = i_wdata[6:0];
        default:                   nxt_st = st_ff;
      endcase
    end
  end

  // ****************************************************************
  // State register
  // ****************************************************************
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      st_ff <= '{uef_pkg::RST_FIFO_BASE, uef_pkg::RST_FIFO_BASE, uef_pkg::RST_ID7,
                 uef_pkg::RST_ID7, uef_pkg::RST_MULT_TT, uef_pkg::RST_ID7,
                 uef_pkg::RST_ID7, uef_pkg::RST_ID7, uef_pkg::RST_MULT_TT,
                 uef_pkg::RST_ID7};
    end else begin
      st_ff <= nxt_st;
    end
  end

  // ****************************************************************
  // Read mux, reserved bits zero
  // ****************************************************************
  always_comb begin
    case (i_rsel)
      uef_pkg::OFS_TX_FIFO_BASE: o_rdata = {3'h0, st_ff.tx_base};             // [RULE1]
      uef_pkg::OFS_RX_FIFO_BASE: o_rdata = {3'h0, st_ff.rx_base};             // [RULE2]
      uef_pkg::OFS_TX_FUNC:      o_rdata = {9'h000, st_ff.tx_func};
      uef_pkg::OFS_TX_HUB_ID:    o_rdata = {8'h00, st_ff.tx_mtt, st_ff.tx_hub}; // [RULE3]
      uef_pkg::OFS_TX_HUB_PORT:  o_rdata = {9'h000, st_ff.tx_port};           // [RULE5]
      uef_pkg::OFS_RX_FUNC:      o_rdata = {9'h000, st_ff.rx_func};
      uef_pkg::OFS_RX_HUB_ID:    o_rdata = {8'h00, st_ff.rx_mtt, st_ff.rx_hub}; // [RULE4]
      uef_pkg::OFS_RX_HUB_PORT:  o_rdata = {9'h000, st_ff.rx_port};
      default:                   o_rdata = 16'h0000;
    endcase
  end

  // Field outputs
  assign ep.tx_fifo_base = st_ff.tx_base;
  assign ep.rx_fifo_base = st_ff.rx_base;
  assign ep.tx_func      = st_ff.tx_func;
  assign ep.tx_hub       = st_ff.tx_hub;
  assign ep.tx_mult_tt   = st_ff.tx_mtt;
  assign ep.tx_port      = st_ff.tx_port;
  assign ep.rx_func      = st_ff.rx_func;
  assign ep.rx_hub       = st_ff.rx_hub;
  assign ep.rx_mult_tt   = st_ff.rx_mtt;
  assign ep.rx_port      = st_ff.rx_port;

endmodule : uef_ep_regs

`default_nettype wire

// [hdl/uef_tok_fmt.sv]
`timescale 1ns/100ps
`default_nettype none

// Forms token address, split fields and FIFO byte start for one endpoint
module uef_tok_fmt (
  // Selected endpoint fields
  uef_ep_if.user            ep,
  // Direction: 1 receive, 0 transmit
  input  wire logic         i_is_rx,
  // Formed fields
  output logic      [15:0]  o_fifo_start,
  output logic      [6:0]   o_func,
  output logic      [6:0]   o_hub,
  output logic      [6:0]   o_port,
  output logic              o_mult_tt
);

  // Byte location is eight times the stored unit count
  function automatic logic [15:0] uef_unit2byte(input logic [12:0] m);
    uef_unit2byte = {m, 3'h0};
  endfunction : uef_unit2byte

  // ****************************************************************
  // Direction select
  // ****************************************************************
  always_comb begin
    if (i_is_rx) begin
      o_fifo_start = uef_unit2byte(ep.rx_fifo_base);  // [RULE2]
      o_func       = ep.rx_func;                      // [RULE6]
      o_hub        = ep.rx_hub;                       // [RULE6]
      o_port       = ep.rx_port;                      // [RULE6]
      o_mult_tt    = ep.rx_mult_tt;                   // [RULE4]
    end else begin
      o_fifo_start = uef_unit2byte(ep.tx_fifo_base);  // [RULE1]
      o_func       = ep.tx_func;                      // [RULE6]
      o_hub        = ep.tx_hub;                       // [RULE6]
      o_port       = ep.tx_port;                      // [RULE6]
      o_mult_tt    = ep.tx_mult_tt;                   // [RULE3]
    end
  end

endmodule : uef_tok_fmt

`default_nettype wire

// [hdl/uef_top.sv]
// Operation
// RULE1 - TX FIFO start is eight times value
// RULE2 - RX FIFO start eight times; bits 15-13 zero
// RULE3 - TX hub: bit7 multi-translator flag, hub 6-0
// RULE4 - RX hub: bit7 multi-translator flag, hub 6-0
// RULE5 - TX hub port 6-0, bit7 reads zero
// RULE6 - Fields address host tokens and splits
`timescale 1ns/100ps
`default_nettype none

module uef_top (
  // Clock and reset
  input  wire logic        i_clk,
  input  wire logic        i_rstn,
  // Register port
  input  wire logic [7:0]  i_addr,
  input  wire logic [15:0] i_wdata,
  input  wire logic        i_wr,
  input  wire logic        i_rd,
  output logic      [15:0] o_rdata,
  // Packet engine query
  input  wire logic [1:0]  i_ep,
  input  wire logic        i_is_rx,
  output logic      [15:0] o_fifo_start,
  output logic      [6:0]  o_func,
  output logic      [6:0]  o_hub,
  output logic      [6:0]  o_port,
  output logic             o_mult_tt
);

  typedef struct packed {
    logic [15:0] rdata;
    logic [15:0] fifo_start;
    logic [6:0]  func;
    logic [6:0]  hub;
    logic [6:0]  port;
    logic        mtt;
  } uef_topst_t;

  uef_topst_t st_ff;
  uef_topst_t nxt_st;

  logic [15:0] ep_rd   [uef_pkg::NUM_EP];
  logic [15:0] ep_fs   [uef_pkg::NUM_EP];
  logic [6:0]  ep_fn   [uef_pkg::NUM_EP];
  logic [6:0]  ep_hb   [uef_pkg::NUM_EP];
  logic [6:0]  ep_pt   [uef_pkg::NUM_EP];
  logic        ep_mt   [uef_pkg::NUM_EP];

  // Address split: endpoint in bits 4-3, register in 2-0, above must be zero
  function automatic logic uef_hit(input logic [7:0] a);
    uef_hit = (a[7:5] == 3'h0);
  endfunction : uef_hit

  // ****************************************************************
  // Endpoint banks
  // ****************************************************************
  for (genvar g = 0; g < uef_pkg::NUM_EP; g++) begin : g_ep
    uef_ep_if epi ();
    uef_ep_regs u_regs (
      .i_clk   (i_clk),
      .i_rstn  (i_rstn),
      .i_wr    (i_wr && uef_hit(i_addr) && (i_addr[4:3] == 2'(g))),
      .i_sel   (i_addr[2:0]),
      .i_wdata (i_wdata),
      .i_rsel  (i_addr[2:0]),
      .o_rdata (ep_rd[g]),
      .ep      (epi.regs)
    );
    uef_tok_fmt u_fmt (
      .ep           (epi.user),
      .i_is_rx      (i_is_rx),
      .o_fifo_start (ep_fs[g]),
      .o_func       (ep_fn[g]),
      .o_hub        (ep_hb[g]),
      .o_port       (ep_pt[g]),
      .o_mult_tt    (ep_mt[g])
    );
  end

  // ****************************************************************
  // Next state: read data and registered token fields
  // ****************************************************************
  always_comb begin
    nxt_st = st_ff;
    // Read data valid only the cycle after the strobe; unmapped reads zero
    if (i_rd && uef_hit(i_addr)) begin
      nxt_st.rdata = ep_rd[i_addr[4:3]];
    end else begin
      nxt_st.rdata = 16'h0000;
    end
    nxt_st.fifo_start = ep_fs[i_ep];  // [RULE1] [RULE2]
    nxt_st.func       = ep_fn[i_ep];  // [RULE6]
    nxt_st.hub        = ep_hb[i_ep];  // [RULE6]
    nxt_st.port       = ep_pt[i_ep];  // [RULE6]
    nxt_st.mtt        = ep_mt[i_ep];  // [RULE3] [RULE4]
  end

  // ****************************************************************
  // State register
  // ****************************************************************
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // Outputs
  assign o_rdata      = st_ff.rdata;
  assign o_fifo_start = st_ff.fifo_start;
  assign o_func       = st_ff.func;
  assign o_hub        = st_ff.hub;
  assign o_port       = st_ff.port;
  assign o_mult_tt    = st_ff.mtt;

endmodule : uef_top

`default_nettype wire

// [tb/uef_top_properties.sv]
`timescale 1ns/100ps
`default_nettype none

// ****************************************************************
// Port checker for the endpoint register bank
// ****************************************************************
module uef_top_chk (
  // Clock and reset
  input  wire logic        i_clk,
  input  wire logic        i_rstn,
  // Register port
  input  wire logic [7:0]  i_addr,
  input  wire logic [15:0] i_wdata,
  input  wire logic        i_wr,
  input  wire logic        i_rd,
  input  wire logic [15:0] o_rdata,
  // Packet engine query
  input  wire logic [1:0]  i_ep,
  input  wire logic        i_is_rx,
  input  wire logic [15:0] o_fifo_start,
  input  wire logic [6:0]  o_func,
  input  wire logic [6:0]  o_hub,
  input  wire logic [6:0]  o_port,
  input  wire logic        o_mult_tt
);
  logic wok;

  // Mapped write to the endpoint being queried
  assign wok = i_wr && (i_addr[7:5] == 3'h0) && (i_addr[4:3] == i_ep);

  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_rstn);

  tx_fifo_start_a: assert property (wok && i_addr[2:0] == 3'h0 && !i_is_rx ##1 $stable(i_ep) && !i_is_rx
    |=> o_fifo_start == {$past(i_wdata[12:0], 2), 3'h0}) else $error("tx fifo start wrong");
  rx_fifo_start_a: assert property (wok && i_addr[2:0] == 3'h1 && i_is_rx ##1 $stable(i_ep) && i_is_rx
    |=> o_fifo_start == {$past(i_wdata[12:0], 2), 3'h0}) else $error("rx fifo start wrong");
  fifo_rsvd_a: assert property (i_rd && i_addr[2:1] == 2'h0 |=> o_rdata[15:13] == 3'h0)
    else $error("fifo base reserved bits set");
  tx_hub_field_a: assert property (wok && i_addr[2:0] == 3'h3 && !i_is_rx ##1 $stable(i_ep) && !i_is_rx
    |=> {o_mult_tt, o_hub} == $past(i_wdata[7:0], 2)) else $error("tx hub fields wrong");
  rx_hub_field_a: assert property (wok && i_addr[2:0] == 3'h6 && i_is_rx ##1 $stable(i_ep) && i_is_rx
    |=> {o_mult_tt, o_hub} == $past(i_wdata[7:0], 2)) else $error("rx hub fields wrong");
  tx_port_field_a: assert property (wok && i_addr[2:0] == 3'h4 && !i_is_rx ##1 $stable(i_ep) && !i_is_rx
    |=> o_port == $past(i_wdata[6:0], 2)) else $error("tx hub port wrong");
  port_rsvd_a: assert property (i_rd && i_addr == {3'h0, i_addr[4:3], 3'h4} |=> o_rdata[15:7] == 9'h000)
    else $error("tx hub port reserved bits set");
  tx_func_field_a: assert property (wok && i_addr[2:0] == 3'h2 && !i_is_rx ##1 $stable(i_ep) && !i_is_rx
    |=> o_func == $past(i_wdata[6:0], 2)) else $error("tx function number wrong");
endmodule : uef_top_chk

bind uef_top uef_top_chk chk_u (.i_clk(i_clk), .i_rstn(i_rstn), .i_addr(i_addr),
  .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_ep(i_ep), .i_is_rx(i_is_rx),
  .o_fifo_start(o_fifo_start), .o_func(o_func), .o_hub(o_hub), .o_port(o_port),
  .o_mult_tt(o_mult_tt));

`default_nettype wire

// [tb/test_usb_endpoint_fifo_and_target_regs.sv]
`timescale 1ns/100ps
`default_nettype none

module test_usb_endpoint_fifo_and_target_regs;
  logic        i_clk   = 1'b0;
  logic        i_rstn  = 1'b0;
  logic [7:0]  i_addr  = 8'h00;
  logic [15:0] i_wdata = 16'h0000;
  logic        i_wr    = 1'b0;
  logic        i_rd    = 1'b0;
  logic [1:0]  i_ep    = 2'h0;
  logic        i_is_rx = 1'b0;
  logic [15:0] o_rdata;
  logic [15:0] o_fifo_start;
  logic [6:0]  o_func;
  logic [6:0]  o_hub;
  logic [6:0]  o_port;
  logic        o_mult_tt;
  logic [15:0] d;
  logic [15:0] model [32];
  logic [15:0] mask  [8] = '{16'h1FFF, 16'h1FFF, 16'h007F, 16'h00FF,
                             16'h007F, 16'h007F, 16'h00FF, 16'h007F};
  int          mismatches = 0;
  int          tests_run  = 0;

  // 100 MHz clock
  always #5 i_clk = ~i_clk;

  uef_top dut_u (.i_clk(i_clk), .i_rstn(i_rstn), .i_addr(i_addr), .i_wdata(i_wdata),
    .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_ep(i_ep), .i_is_rx(i_is_rx),
    .o_fifo_start(o_fifo_start), .o_func(o_func), .o_hub(o_hub), .o_port(o_port),
    .o_mult_tt(o_mult_tt));

  // ****************************************************************
  // Access tasks
  // ****************************************************************
  task chk(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task wr(input logic [7:0] a, input logic [15:0] dat);
    @(posedge i_clk);
    i_wr    <= 1'b1;
    i_addr  <= a;
    i_wdata <= dat;
    @(posedge i_clk);
    i_wr <= 1'b0;
  endtask : wr

  task rd(input logic [7:0] a, input logic [15:0] exp);
    @(posedge i_clk);
    i_rd   <= 1'b1;
    i_addr <= a;
    @(posedge i_clk);
    i_rd <= 1'b0;
    #1;
    chk(o_rdata, exp);
  endtask : rd

  task query(input int e, input logic rx);
    int b;
    b = e * 8;
    @(posedge i_clk);
    i_ep    <= e[1:0];
    i_is_rx <= rx;
    repeat (2) @(posedge i_clk);
    #1;
    chk(o_fifo_start, {model[b + (rx ? 1 : 0)][12:0], 3'h0});
    chk({8'h00, o_mult_tt, o_hub}, {8'h00, model[b + (rx ? 6 : 3)][7:0]});
    chk({9'h000, o_port}, {9'h000, model[b + (rx ? 7 : 4)][6:0]});
    chk({9'h000, o_func}, {9'h000, model[b + (rx ? 5 : 2)][6:0]});
  endtask : query

  task end_of_test;
    $display("Comparisons %0d, mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : end_of_test

  // ****************************************************************
  // Test sequence
  // ****************************************************************
  initial begin
    repeat (6) @(posedge i_clk);
    i_rstn <= 1'b1;
    // Reset values of every register
    for (int a = 0; a < 32; a++) begin
      model[a] = 16'h0000;
      rd(a[7:0], 16'h0000);
    end
    // All ones then a pattern, read back and seen by the engine
    for (int p = 0; p < 2; p++) begin
      for (int a = 0; a < 32; a++) begin
        d = (p == 0) ? 16'hFFFF : (16'h5A5A ^ {a[7:0], a[7:0]});
        wr(a[7:0], d);
        model[a] = d & mask[a % 8];
        rd(a[7:0], model[a]);
      end
      for (int e = 0; e < 4; e++) begin
        query(e, 1'b0);
        query(e, 1'b1);
      end
    end
    // Unmapped places ignore writes and read zero
    wr(8'h20, 16'hFFFF);
    rd(8'h20, 16'h0000);
    wr(8'hE3, 16'h0000);
    rd(8'h03, model[3]);
    // Reset in mid-run clears the bank
    @(posedge i_clk);
    i_rstn <= 1'b0;
    repeat (2) @(posedge i_clk);
    i_rstn <= 1'b1;
    for (int a = 0; a < 32; a++) begin
      model[a] = 16'h0000;
    end
    rd(8'h1B, 16'h0000);
    query(3, 1'b0);
    query(3, 1'b1);
    end_of_test();
  end

  // Watchdog against a hang
  initial begin
    #100000;
    mismatches++;
    end_of_test();
  end
endmodule : test_usb_endpoint_fifo_and_target_regs

`default_nettype wire
